// >>> src/eis_pkg.sv
// Constants for the external interrupt and shared pin select block.
// Assumes a 20 MHz system clock and a plain strobe register port.
package eis_pkg;
   // Register offsets
   localparam logic [3:0] EIS_OFS_CTRL   = 4'h0;
   localparam logic [3:0] EIS_OFS_STATUS = 4'h1;
   localparam logic [3:0] EIS_OFS_MASK   = 4'h2;
   localparam logic [3:0] EIS_OFS_DACLO  = 4'h3;
   localparam logic [3:0] EIS_OFS_DACHI  = 4'h4;
   localparam logic [3:0] EIS_OFS_PINS   = 4'h5;
   localparam logic [3:0] EIS_OFS_TIMSEL = 4'h6;
   // Control field positions
   localparam int EIS_CTL_EDGE_A = 0;
   localparam int EIS_CTL_EDGE_B = 1;
   localparam int EIS_CTL_ZC     = 2;
   localparam int EIS_CTL_DAC    = 3;
   localparam int EIS_CTL_CMP    = 4;
   localparam int EIS_CTL_PANEL  = 5;
   localparam int EIS_CTL_COMS_L = 6;
   // Reset values
   localparam logic [7:0] EIS_CTRL_RST = 8'h00;
   localparam logic [1:0] EIS_MASK_RST = 2'h3;
   // Noise filter: 3 samples must agree
   localparam int EIS_FILT_LEN = 3;
   // Common count encodings
   localparam logic [1:0] EIS_COM2 = 2'h0;
   localparam logic [1:0] EIS_COM3 = 2'h1;
   localparam logic [1:0] EIS_COM4 = 2'h2;
endpackage : eis_pkg

// >>> src/eis_top.sv
// External interrupt inputs with filters, and shared pin mode select.
// Assumes async pins, one 20 MHz clock, and a strobe register port.
//
// Summary of operation
// - Request flag set on the edge chosen by each edge-select bit.
// - Inputs pass a noise filter; filtered level readable in the pins register.
// - Input a clocks timer 1, input b timer 2; edges still set flags.
// - Zero-cross enable routes input b to zero-cross detection.
// - Six-bit converter code from four low and two high data bits.
// - Converter on, comparator off: converter drives shared analog pin.
// - Converter off, comparator on: pin is comparator inverting input.
// - Both on: converter feeds comparator internally; pin unused.
// - Reset clears both enables; pin then high impedance.
// - Panel enable 0: segment pins plain outputs; commons 0 and 1 unused.
// - Panel supports 14x2, 13x3 and 12x4 segment and common layouts.
// - Low reset overrides everything and releases standby.
// - Reset makes shared port pins high-impedance plain inputs.
`timescale 1ns/10ps
module eis_top
   import eis_pkg::*;
(
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_resetn,
   // Register port
   input  wire logic [3:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic      [7:0] o_rdata,
   // External interrupt pins
   input  wire logic       i_ext_irq_in_a,
   input  wire logic       i_ext_irq_in_b,
   // Timer and zero-cross hooks
   output logic            o_timer1_clk,
   output logic            o_timer2_clk,
   output logic            o_zero_cross,
   output logic            o_irq,
   // Standby
   input  wire logic       i_standby_req,
   output logic            o_standby,
   // Analog select
   output logic      [5:0] o_dac_code,
   output logic            o_dac_to_pin,
   output logic            o_shared_analog_pin_oe,
   output logic            o_cmp_from_pin,
   output logic            o_cmp_from_dac,
   output logic            o_converter_on,
   // Panel select
   output logic            o_panel_mode,
   output logic      [1:0] o_common_count,
   output logic      [3:0] o_common_drive_en,
   output logic     [13:0] o_segment_drive_en,
   output logic     [13:0] o_plain_out_en,
   // Shared port pins
   output logic            o_port_pins_reset
);

   typedef struct packed {
      logic [1:0] sync1;
      logic [1:0] sync2;
      logic [1:0] filt;
      logic [1:0] prev;
      logic [3:0] hist_a;
      logic [3:0] hist_b;
      logic [7:0] ctrl;
      logic [1:0] status;
      logic [1:0] mask;
      logic [3:0] dac_lo;
      logic [1:0] dac_hi;
      logic [1:0] timsel;
      logic       standby;
      logic [7:0] rdata;
   } eis_state_t;

   eis_state_t s_q, s_d;
   logic [1:0] edge_hit;

   function automatic logic edge_seen(input logic prv, input logic cur, input logic rise);
      edge_seen = rise ? (!prv && cur) : (prv && !cur);
   endfunction : edge_seen

   always_comb begin
      s_d = s_q;
      s_d.sync1 = {i_ext_irq_in_b, i_ext_irq_in_a};
      s_d.sync2 = s_q.sync1;
      // Majority-free filter: level changes only when samples agree
      s_d.hist_a = {s_q.hist_a[2:0], s_q.sync2[0]};
      s_d.hist_b = {s_q.hist_b[2:0], s_q.sync2[1]};
      if (s_q.hist_a[EIS_FILT_LEN-1:0] == '1) begin
         s_d.filt[0] = 1'b1;
      end else if (s_q.hist_a[EIS_FILT_LEN-1:0] == '0) begin
         s_d.filt[0] = 1'b0;
      end
      if (s_q.hist_b[EIS_FILT_LEN-1:0] == '1) begin
         s_d.filt[1] = 1'b1;
      end else if (s_q.hist_b[EIS_FILT_LEN-1:0] == '0) begin
         s_d.filt[1] = 1'b0;
      end
      s_d.prev = s_q.filt;
      // Register writes; status clear is write-one
      if (i_wr) begin
         unique case (i_addr)
            EIS_OFS_CTRL:   s_d.ctrl = i_wdata;
            EIS_OFS_STATUS: s_d.status = s_q.status & ~i_wdata[1:0];
            EIS_OFS_MASK:   s_d.mask = i_wdata[1:0];
            EIS_OFS_DACLO:  s_d.dac_lo = i_wdata[3:0];
            EIS_OFS_DACHI:  s_d.dac_hi = i_wdata[3:2];
            EIS_OFS_TIMSEL: s_d.timsel = i_wdata[1:0];
            default: ;
         endcase
      end
      // Set wins over a clear in the same cycle
      s_d.status = s_d.status | edge_hit;
      // Any pending request with its mask bit set wakes from standby, but a standby request in the same cycle wins
      if (i_standby_req) begin
         s_d.standby = 1'b1;
      end else if (|(s_q.status & s_q.mask)) begin
         s_d.standby = 1'b0;
      end
      s_d.rdata = 8'h00;
      if (i_rd) begin
         unique case (i_addr)
            EIS_OFS_CTRL:   s_d.rdata = s_q.ctrl;
            EIS_OFS_STATUS: s_d.rdata = {6'h00, s_q.status};
            EIS_OFS_MASK:   s_d.rdata = {6'h00, s_q.mask};
            EIS_OFS_DACLO:  s_d.rdata = {4'h0, s_q.dac_lo};
            EIS_OFS_DACHI:  s_d.rdata = {4'h0, s_q.dac_hi, 2'h0};
            EIS_OFS_PINS:   s_d.rdata = {6'h00, s_q.filt};
            EIS_OFS_TIMSEL: s_d.rdata = {6'h00, s_q.timsel};
            default:        s_d.rdata = 8'h00;
         endcase
      end
      if (!i_resetn) begin
         s_d = '0;
         s_d.ctrl = EIS_CTRL_RST;
         s_d.mask = EIS_MASK_RST;
      end
   end

   // Edge per selected polarity; timer edges count too
   assign edge_hit[0] = edge_seen(s_q.prev[0], s_q.filt[0], s_q.ctrl[EIS_CTL_EDGE_A]);
   assign edge_hit[1] = edge_seen(s_q.prev[1], s_q.filt[1], s_q.ctrl[EIS_CTL_EDGE_B]);

   always_ff @(posedge i_clk) begin
      s_q <= s_d;
   end

   logic dac_en, cmp_en, pnl_en;
   logic [1:0] coms;
   assign dac_en = s_q.ctrl[EIS_CTL_DAC];
   assign cmp_en = s_q.ctrl[EIS_CTL_CMP];
   assign pnl_en = s_q.ctrl[EIS_CTL_PANEL];
   assign coms   = s_q.ctrl[EIS_CTL_COMS_L+1:EIS_CTL_COMS_L];

   assign o_rdata   = s_q.rdata;
   assign o_irq     = |(s_q.status & s_q.mask);
   assign o_standby = s_q.standby;
   // Input a clocks timer 1, input b timer 2 when selected
   assign o_timer1_clk = s_q.timsel[0] & s_q.filt[0];
   assign o_timer2_clk = s_q.timsel[1] & s_q.filt[1];
   assign o_zero_cross = s_q.ctrl[EIS_CTL_ZC] & s_q.filt[1];
   // Code built from both data fields
   assign o_dac_code = {s_q.dac_hi, s_q.dac_lo};
   // Pin driven only in converter-only mode
   assign o_dac_to_pin           = dac_en & !cmp_en;
   assign o_shared_analog_pin_oe = dac_en & !cmp_en;
   assign o_cmp_from_pin = !dac_en & cmp_en;
   assign o_cmp_from_dac = dac_en & cmp_en;
   assign o_converter_on = dac_en;
   assign o_panel_mode   = pnl_en;
   assign o_common_count = coms;
   // Shared pins 12 and 13 become commons 3 and 2 as needed
   always_comb begin
      o_common_drive_en  = 4'h0;
      o_segment_drive_en = 14'h0000;
      o_plain_out_en     = 14'h3FFF;
      if (pnl_en) begin
         o_plain_out_en = 14'h0000;
         unique case (coms)
            EIS_COM3: begin
               o_common_drive_en  = 4'h7;
               o_segment_drive_en = 14'h1FFF;
            end
            EIS_COM4: begin
               o_common_drive_en  = 4'hF;
               o_segment_drive_en = 14'h0FFF;
            end
            default: begin
               o_common_drive_en  = 4'h3;
               o_segment_drive_en = 14'h3FFF;
            end
         endcase
      end
   end
   // Port pins held as inputs while reset is low
   assign o_port_pins_reset = !i_resetn;

   zero_pin_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (dac_en && cmp_en) |-> !o_shared_analog_pin_oe)
      else $error("pin driven in internal mode");
   drive_pin_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_shared_analog_pin_oe == (dac_en && !cmp_en))
      else $error("pin drive mismatch");
   cmp_pin_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (!dac_en && cmp_en) |-> (o_cmp_from_pin && !o_cmp_from_dac))
      else $error("comparator source wrong");
   reset_clear_a: assert property (@(posedge i_clk)
      !i_resetn |=> (!o_shared_analog_pin_oe && s_q.ctrl == EIS_CTRL_RST && !o_standby))
      else $error("reset did not clear");
   edge_flag_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      edge_hit[0] |=> s_q.status[0])
      else $error("flag a not set");
   sync_delay_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      $rose(s_q.filt[0]) |-> $past(s_q.sync2[0], 2) && $past(s_q.sync2[0], 4))
      else $error("filter rose early");
   once_edge_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      edge_hit[1] |=> !edge_hit[1])
      else $error("double edge b");
   dac_code_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_wr && i_addr == EIS_OFS_DACLO) |=> o_dac_code[3:0] == $past(i_wdata[3:0]))
      else $error("code low wrong");
   plain_out_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      !pnl_en |-> (o_plain_out_en == 14'h3FFF && o_common_drive_en == 4'h0))
      else $error("plain mode wrong");
   seg_count_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (pnl_en && coms == EIS_COM4) |-> $countones(o_segment_drive_en) == 12)
      else $error("layout wrong");
   three_com_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (pnl_en && coms == EIS_COM3) |->
      ($countones(o_segment_drive_en) == 13 && o_common_drive_en == 4'h7))
      else $error("three common layout wrong");
   panel_on_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      pnl_en |-> o_plain_out_en == 14'h0000)
      else $error("plain outputs on in panel mode");
   flag_b_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      edge_hit[1] |=> s_q.status[1])
      else $error("flag b not set");
   flag_clear_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_wr && i_addr == EIS_OFS_STATUS && i_wdata[0] && !edge_hit[0]) |=> !s_q.status[0])
      else $error("flag a not cleared");
   filt_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (s_q.hist_a[EIS_FILT_LEN-1:0] != '1 && s_q.hist_a[EIS_FILT_LEN-1:0] != '0)
      |=> $stable(s_q.filt[0]))
      else $error("filter moved without agreement");
   read_idle_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      !i_rd |=> o_rdata == 8'h00)
      else $error("read data not idle");
   timer_clk_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      !s_q.timsel[1] |-> !o_timer2_clk)
      else $error("timer 2 clock leaked");
   zero_off_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      !s_q.ctrl[EIS_CTL_ZC] |-> !o_zero_cross)
      else $error("zero cross leaked");
   dac_high_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_wr && i_addr == EIS_OFS_DACHI) |=> o_dac_code[5:4] == $past(i_wdata[3:2]))
      else $error("code high wrong");
   pin_idle_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (!dac_en && !cmp_en) |-> (!o_shared_analog_pin_oe && !o_cmp_from_pin && !o_cmp_from_dac))
      else $error("idle analog mode wrong");
   standby_wake_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (|(s_q.status & s_q.mask) && !i_standby_req) |=> !o_standby)
      else $error("standby not released");
   port_reset_a: assert property (@(posedge i_clk)
      !i_resetn |-> o_port_pins_reset)
      else $error("port pins not held in reset");

   cov_zc_c:    cover property (@(posedge i_clk) disable iff (!i_resetn) $rose(o_zero_cross));
   cov_stby_c:  cover property (@(posedge i_clk) disable iff (!i_resetn) $fell(o_standby));
   cov_irq_c:   cover property (@(posedge i_clk) disable iff (!i_resetn) $rose(o_irq));
   cov_dac_c:   cover property (@(posedge i_clk) disable iff (!i_resetn) o_cmp_from_dac);
   cov_panel_c: cover property (@(posedge i_clk) disable iff (!i_resetn)
      pnl_en && coms == EIS_COM3);
endmodule : eis_top

// >>> test/eis_irq_src.sv
// Far-side model: two external interrupt sources driving the pins.
// Assumes the caller is aligned to a rising edge of i_clk.
`timescale 1ns/10ps
module eis_irq_src (
   // Clock
   input  wire logic i_clk,
   // Pin levels
   output logic      o_pin_a,
   output logic      o_pin_b
);
   initial begin
      o_pin_a = 1'h0;
      o_pin_b = 1'h0;
   end
   // Level changes right after an edge, then held for hold cycles
   task automatic set_pin(input bit ch, input bit lvl, input int hold);
      @(posedge i_clk);
      if (ch) o_pin_b <= lvl;
      else o_pin_a <= lvl;
      repeat (hold) @(posedge i_clk);
   endtask : set_pin
endmodule : eis_irq_src

// >>> test/test_ext_int_and_shared_pin_select.sv
// Self-checking bench for the interrupt and shared pin select block.
// Assumes the strobe register port and the eis_irq_src pin model.
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
   $display("wrong value at %0t: got %h, expected %h", $time, (a), (e)); end end
module test_ext_int_and_shared_pin_select;
   import eis_pkg::*;
   logic i_clk = 1'h0, i_resetn = 1'h0, i_wr = 1'h0, i_rd = 1'h0, i_standby_req = 1'h0;
   logic [3:0] i_addr = 4'h0;
   logic [7:0] i_wdata = 8'h00, o_rdata;
   logic pa, pb, o_irq, o_standby, t1, t2, zc, d2p, oe, cfp, cfd, con, pm, prst;
   logic [5:0] o_dac_code;
   logic [1:0] o_common_count;
   logic [3:0] o_common_drive_en;
   logic [13:0] o_segment_drive_en, o_plain_out_en;
   int n_mismatch = 0, checks = 0, seed = 58;
   always #25 i_clk = ~i_clk;
   eis_irq_src eis_irq_src_inst (.i_clk(i_clk), .o_pin_a(pa), .o_pin_b(pb));
   eis_top eis_top_inst (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_ext_irq_in_a(pa), .i_ext_irq_in_b(pb), .o_timer1_clk(t1), .o_timer2_clk(t2),
      .o_zero_cross(zc), .o_irq(o_irq), .i_standby_req(i_standby_req),
      .o_standby(o_standby), .o_dac_code(o_dac_code), .o_dac_to_pin(d2p),
      .o_shared_analog_pin_oe(oe), .o_cmp_from_pin(cfp), .o_cmp_from_dac(cfd),
      .o_converter_on(con), .o_panel_mode(pm), .o_common_count(o_common_count),
      .o_common_drive_en(o_common_drive_en), .o_segment_drive_en(o_segment_drive_en),
      .o_plain_out_en(o_plain_out_en), .o_port_pins_reset(prst));
   function automatic logic [3:0] com_exp(input logic [1:0] cc);
      return (cc == EIS_COM3) ? 4'h7 : (cc == EIS_COM4) ? 4'hF : 4'h3;
   endfunction : com_exp
   function automatic logic [13:0] seg_exp(input logic [1:0] cc);
      return (cc == EIS_COM3) ? 14'h1FFF : (cc == EIS_COM4) ? 14'h0FFF : 14'h3FFF;
   endfunction : seg_exp
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_addr <= a; i_wdata <= d; i_wr <= 1'h1;
      @(posedge i_clk);
      i_wr <= 1'h0;
      #1;
   endtask : wr
   // Read data stands only in the cycle after the strobe
   task automatic rchk(input logic [3:0] a, input logic [7:0] e);
      @(posedge i_clk);
      i_addr <= a; i_rd <= 1'h1;
      @(posedge i_clk);
      i_rd <= 1'h0;
      #1 `CHK(o_rdata, e)
   endtask : rchk
   task automatic final_report;
      $display("checks %0d, mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : final_report
   initial begin
      repeat (5000) @(posedge i_clk);
      n_mismatch++;
      final_report();
   end
   initial begin
      logic [7:0] lo, hi;
      @(posedge i_clk); #1 `CHK(prst, 1'h1)
      repeat (3) @(posedge i_clk);
      i_resetn <= 1'h1;
      #1 `CHK(oe, 1'h0)
      `CHK(o_plain_out_en, 14'h3FFF)
      rchk(EIS_OFS_CTRL, EIS_CTRL_RST);
      rchk(EIS_OFS_MASK, {6'h00, EIS_MASK_RST});
      rchk(4'hF, 8'h00);
      $display("test reset done");
      for (int m = 0; m < 4; m++) begin
         wr(EIS_OFS_CTRL, 8'(m << EIS_CTL_DAC));
         `CHK(d2p, 1'(m == 1))
         `CHK(oe, 1'(m == 1))
         `CHK(cfp, 1'(m == 2))
         `CHK(cfd, 1'(m == 3))
         `CHK(con, 1'(m == 1 || m == 3))
      end
      repeat (6) begin
         lo = 8'($random(seed));
         hi = 8'($random(seed));
         wr(EIS_OFS_DACLO, lo);
         wr(EIS_OFS_DACHI, hi);
         `CHK(o_dac_code, {hi[3:2], lo[3:0]})
      end
      $display("test analog modes done");
      for (int c = 0; c < 3; c++) begin
         wr(EIS_OFS_CTRL, 8'h20 | 8'(c << EIS_CTL_COMS_L));
         `CHK(o_common_drive_en, com_exp(2'(c)))
         `CHK(o_segment_drive_en, seg_exp(2'(c)))
         `CHK(o_plain_out_en, 14'h0000)
         `CHK(pm, 1'h1)
         `CHK(o_common_count, 2'(c))
      end
      wr(EIS_OFS_CTRL, 8'h01);
      `CHK(o_common_drive_en, 4'h0)
      $display("test panel done");
      eis_irq_src_inst.set_pin(1'b0, 1'b1, 8);
      rchk(EIS_OFS_STATUS, 8'h01);
      `CHK(o_irq, 1'h1)
      rchk(EIS_OFS_PINS, 8'h01);
      eis_irq_src_inst.set_pin(1'b1, 1'b1, 8);
      rchk(EIS_OFS_STATUS, 8'h01);
      eis_irq_src_inst.set_pin(1'b1, 1'b0, 8);
      rchk(EIS_OFS_STATUS, 8'h03);
      wr(EIS_OFS_STATUS, 8'h03);
      `CHK(o_irq, 1'h0)
      // One-cycle pulse must not survive the filter
      eis_irq_src_inst.set_pin(1'b1, 1'b1, 0);
      eis_irq_src_inst.set_pin(1'b1, 1'b0, 8);
      rchk(EIS_OFS_STATUS, 8'h00);
      wr(EIS_OFS_MASK, 8'h00);
      eis_irq_src_inst.set_pin(1'b0, 1'b0, 8);
      eis_irq_src_inst.set_pin(1'b0, 1'b1, 8);
      rchk(EIS_OFS_STATUS, 8'h01);
      `CHK(o_irq, 1'h0)
      $display("test edges done");
      wr(EIS_OFS_TIMSEL, 8'h03);
      wr(EIS_OFS_CTRL, 8'h04);
      `CHK(t1, 1'h1)
      `CHK(t2, 1'h0)
      eis_irq_src_inst.set_pin(1'b1, 1'b1, 8);
      #1 `CHK(t2, 1'h1)
      `CHK(zc, 1'h1)
      eis_irq_src_inst.set_pin(1'b1, 1'b0, 8);
      rchk(EIS_OFS_STATUS, 8'h03);
      $display("test timer hooks done");
      wr(EIS_OFS_STATUS, 8'h03);
      @(posedge i_clk);
      i_standby_req <= 1'h1;
      @(posedge i_clk);
      i_standby_req <= 1'h0;
      repeat (2) @(posedge i_clk);
      #1 `CHK(o_standby, 1'h1)
      @(posedge i_clk);
      i_resetn <= 1'h0;
      @(posedge i_clk);
      #1 `CHK(o_standby, 1'h0)
      `CHK(prst, 1'h1)
      `CHK(oe, 1'h0)
      @(posedge i_clk);
      i_resetn <= 1'h1;
      rchk(EIS_OFS_CTRL, 8'h00);
      $display("test standby done");
      final_report();
   end
endmodule : test_ext_int_and_shared_pin_select
